// File: include/dtc_cfg.svh
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// register offsets (word addresses, one register per address)
`define DTC_OFS_CTRL    4'h0
`define DTC_OFS_MODE    4'h1
`define DTC_OFS_TL0     4'h2
`define DTC_OFS_TH0     4'h3
`define DTC_OFS_TL1     4'h4
`define DTC_OFS_TH1     4'h5
`define DTC_OFS_IRQ_ST  4'h6
`define DTC_OFS_IRQ_MSK 4'h7
// machine cycle
`define DTC_MC_CLKS     6
`define DTC_PHASE_W     3
`define DTC_PHASE_LAST  3'h5
`define DTC_PHASE_SAMP  3'h4
`define DTC_PHASE_UPD   3'h1
// control register bit positions
`define DTC_B_TF1 7
`define DTC_B_TR1 6
`define DTC_B_TF0 5
`define DTC_B_TR0 4
`define DTC_B_IE1 3
`define DTC_B_IT1 2
`define DTC_B_IE0 1
`define DTC_B_IT0 0
// mode register nibble fields
`define DTC_M_GATE 3
`define DTC_M_CT   2
// interrupt status bits
`define DTC_ST_OVF0 0
`define DTC_ST_OVF1 1
`define DTC_ST_EXT0 2
`define DTC_ST_EXT1 3
`define DTC_ST_W    4
`define DTC_LOW5    5'h1f
`endif

// File: include/dtc_pkg.sv
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_13,
    DTC_MODE_16,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtc_count_s;
  typedef struct packed {
    logic [2:0] ph;   // phase within machine cycle
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;   // three sync stages for the pins
    logic [1:0] flt;  // level on which stages two and three last agreed
    logic [1:0] prev; // last machine-cycle sample of count pins
    logic [1:0] pend; // pending count, applied at update phase
  } dtc_tick_s;
endpackage

// File: hw/dtc_tick.sv
`timescale 1ns/1ps
`include "dtc_cfg.svh"
// =====================================================
// machine-cycle phase and count pin sampling
module dtc_tick (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // raw count pins
  input  wire logic [1:0] count_pin,
  // pulses
  output logic            mc_tick,
  output logic [1:0]      pin_fall
);
  dtc_pkg::dtc_tick_s st_q, st_d;

  // three-stage sync; a one-clock glitch never reaches the sampler
  always_comb begin
    st_d = st_q;
    mc_tick = 1'b0;
    pin_fall = 2'b00;
    st_d.s1 = count_pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.flt = (st_q.s2 & st_q.s3) | (st_q.flt & (st_q.s2 | st_q.s3));
    if (st_q.ph == `DTC_PHASE_LAST) begin
      st_d.ph = '0;
    end else begin
      st_d.ph = st_q.ph + 3'h1;
    end
    // one machine cycle per six clocks
    mc_tick = (st_q.ph == `DTC_PHASE_LAST);
    // sample once per cycle; high then low is an edge
    if (st_q.ph == `DTC_PHASE_SAMP) begin
      st_d.prev = st_q.flt;
      st_d.pend = st_q.pend | (st_q.prev & ~st_q.flt);
    end
    // edge shows in counter at next cycle's update phase
    if (st_q.ph == `DTC_PHASE_UPD) begin
      pin_fall = st_q.pend;
      st_d.pend = 2'b00;
    end
  end

  // s2 second/third stage agreement: value taken after both agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
endmodule

// File: hw/dtc_top.sv
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
// =====================================================
// Functional notes
// - timer function counts one per machine cycle of six clocks
// - count pin sampled once per machine cycle; high then low counts
// - counted edge appears at update phase of following machine cycle
// - edge detection takes two machine cycles; max rate clock over twelve
// - two-bit mode: 13-bit, 16-bit, 8-bit reload, split or stop
// - 13-bit mode uses high byte plus low five bits prescaler
// - rollover of active counter sets the overflow flag
// - count only with run set and gate clear or irq pin high
// - starting the timer never clears the count
// - timer zero mirrors timer one with own controls and gate
// - 16-bit mode cascades both bytes, no prescaler
// - reload mode: low byte overflow sets flag, reloads from high byte
// - timer one in mode three holds count like run cleared
// - split mode: high byte zero counts cycles using timer one controls
// - timer zero split: timer one runs outside mode three, no flag
// - type bit selects falling edge or low level external irq
// - select bit picks machine cycles or count pin
module dtc_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pins
  input  wire logic [1:0]  count_pin,
  input  wire logic [1:0]  ext_irq_pin_n,
  // acknowledges and events
  input  wire logic [1:0]  ovf_ack,
  input  wire logic [1:0]  ext_irq_ack,
  output logic             timer1_ovf_pulse,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]             ctrl;
    logic [7:0]             mode;
    dtc_pkg::dtc_count_s    c0;
    dtc_pkg::dtc_count_s    c1;
    logic [`DTC_ST_W-1:0]   st;
    logic [`DTC_ST_W-1:0]   msk;
    logic [2:0]             irs1;
    logic [1:0]             irs2;
    logic [1:0]             irs3;
    logic [1:0]             iflt;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   ovf1p;
  } dtc_state_s;

  dtc_state_s st_q, st_d;
  logic       mc_tick;
  logic [1:0] pin_fall;

  // =====================================================
  // machine cycle and count pins
  dtc_tick u_tick (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .count_pin (count_pin),
    .mc_tick   (mc_tick),
    .pin_fall  (pin_fall)
  );

  // =====================================================
  // counting, flags and bus
  logic [1:0]  pin_q;       // synchronised irq pins, high = inactive
  logic [1:0]  ext_fall;
  logic [3:0]  nib0, nib1;
  logic        en0, en1, inc0, inc1, th0_inc;
  logic        ovf0, ovf1, ovf_th0;
  logic [1:0]  m0, m1;
  logic [16:0] sum16;
  logic [8:0]  sum8;
  logic [13:0] sum13;
  logic        rd_hit, wr_hit;
  logic [31:0] rmux;

  always_comb begin
    st_d = st_q;
    pin_q = st_q.iflt;
    // fall taken when stages two and three agree low after a high
    ext_fall = st_q.iflt & ~st_q.irs2 & ~st_q.irs3;
    nib0 = st_q.mode[3:0];
    nib1 = st_q.mode[7:4];
    m0 = nib0[1:0];
    m1 = nib1[1:0];
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf_th0 = 1'b0;
    sum16 = '0;
    sum8 = '0;
    sum13 = '0;
    rmux = '0;
    st_d.ovf1p = 1'b0;
    // pin sync, changes taken when stages two and three agree
    st_d.irs1 = {1'b0, ext_irq_pin_n};
    st_d.irs2 = st_q.irs1[1:0];
    st_d.irs3 = st_q.irs2;
    st_d.iflt = (st_q.irs2 & st_q.irs3) | (st_q.iflt & (st_q.irs2 | st_q.irs3));
    // gating; pin_q high means pin high
    en0 = st_q.ctrl[`DTC_B_TR0] && (!nib0[`DTC_M_GATE] || pin_q[0]);
    // split timer zero owns the run bit, so timer one runs on mode and its gate alone
    en1 = (m0 == dtc_pkg::DTC_MODE_SPLIT || st_q.ctrl[`DTC_B_TR1])
          && (!nib1[`DTC_M_GATE] || pin_q[1]);
    // timer one stops in mode three
    if (m1 == dtc_pkg::DTC_MODE_SPLIT) begin
      en1 = 1'b0;
    end
    // source select
    inc0 = en0 && (nib0[`DTC_M_CT] ? pin_fall[0] : mc_tick);
    inc1 = en1 && (nib1[`DTC_M_CT] ? pin_fall[1] : mc_tick);
    // split high byte runs on timer one's run bit, cycles only
    th0_inc = (m0 == dtc_pkg::DTC_MODE_SPLIT) && st_q.ctrl[`DTC_B_TR1] && mc_tick;

    // timer zero
    if (inc0) begin
      unique case (m0)
        dtc_pkg::DTC_MODE_13: begin
          sum13 = {st_q.c0.high, st_q.c0.low[4:0]} + 14'h1;
          st_d.c0.high = sum13[12:5];
          st_d.c0.low = {st_q.c0.low[7:5], sum13[4:0]};
          ovf0 = sum13[13];
        end
        dtc_pkg::DTC_MODE_16: begin
          sum16 = {1'b0, st_q.c0} + 17'h1;
          st_d.c0 = sum16[15:0];
          ovf0 = sum16[16];
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          sum8 = {1'b0, st_q.c0.low} + 9'h1;
          st_d.c0.low = sum8[8] ? st_q.c0.high : sum8[7:0];
          ovf0 = sum8[8];
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          sum8 = {1'b0, st_q.c0.low} + 9'h1;
          st_d.c0.low = sum8[7:0];
          ovf0 = sum8[8];
        end
      endcase
    end
    if (th0_inc) begin
      {ovf_th0, st_d.c0.high} = {1'b0, st_q.c0.high} + 9'h1;
    end

    // timer one, same modes
    if (inc1) begin
      unique case (m1)
        dtc_pkg::DTC_MODE_13: begin
          sum13 = {st_q.c1.high, st_q.c1.low[4:0]} + 14'h1;
          st_d.c1.high = sum13[12:5];
          st_d.c1.low = {st_q.c1.low[7:5], sum13[4:0]};
          ovf1 = sum13[13];
        end
        dtc_pkg::DTC_MODE_16: begin
          sum16 = {1'b0, st_q.c1} + 17'h1;
          st_d.c1 = sum16[15:0];
          ovf1 = sum16[16];
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          sum8 = {1'b0, st_q.c1.low} + 9'h1;
          st_d.c1.low = sum8[8] ? st_q.c1.high : sum8[7:0];
          ovf1 = sum8[8];
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          ovf1 = 1'b0;
        end
      endcase
    end
    // baud pulse always, flag only when timer zero not split
    st_d.ovf1p = ovf1;

    // bus access, one wait cycle then ack
    rd_hit = avs_read && !st_q.ack;
    wr_hit = avs_write && st_q.ack; // write lands where waitrequest is low
    st_d.ack = (avs_read || avs_write) && !st_q.ack;
    unique case (avs_address)
      `DTC_OFS_CTRL:    rmux = {24'h0, st_q.ctrl};
      `DTC_OFS_MODE:    rmux = {24'h0, st_q.mode};
      `DTC_OFS_TL0:     rmux = {24'h0, st_q.c0.low};
      `DTC_OFS_TH0:     rmux = {24'h0, st_q.c0.high};
      `DTC_OFS_TL1:     rmux = {24'h0, st_q.c1.low};
      `DTC_OFS_TH1:     rmux = {24'h0, st_q.c1.high};
      `DTC_OFS_IRQ_ST:  rmux = {28'h0, st_q.st};
      `DTC_OFS_IRQ_MSK: rmux = {28'h0, st_q.msk};
      default:          rmux = '0;
    endcase
    if (rd_hit) begin
      st_d.rdata = rmux;
      if (avs_address == `DTC_OFS_IRQ_ST) begin
        st_d.st = '0; // read clears
      end
    end
    // software writes; count writes never touched by run bit
    if (wr_hit) begin
      unique case (avs_address)
        `DTC_OFS_CTRL:    st_d.ctrl = avs_writedata[7:0];
        `DTC_OFS_MODE:    st_d.mode = avs_writedata[7:0];
        `DTC_OFS_TL0:     st_d.c0.low = avs_writedata[7:0];
        `DTC_OFS_TH0:     st_d.c0.high = avs_writedata[7:0];
        `DTC_OFS_TL1:     st_d.c1.low = avs_writedata[7:0];
        `DTC_OFS_TH1:     st_d.c1.high = avs_writedata[7:0];
        `DTC_OFS_IRQ_MSK: st_d.msk = avs_writedata[`DTC_ST_W-1:0];
        default:          st_d.msk = st_d.msk;
      endcase
    end

    // hardware clears by acknowledge
    if (ovf_ack[0]) st_d.ctrl[`DTC_B_TF0] = 1'b0;
    if (ovf_ack[1]) st_d.ctrl[`DTC_B_TF1] = 1'b0;
    if (ext_irq_ack[0] && st_q.ctrl[`DTC_B_IT0]) st_d.ctrl[`DTC_B_IE0] = 1'b0;
    if (ext_irq_ack[1] && st_q.ctrl[`DTC_B_IT1]) st_d.ctrl[`DTC_B_IE1] = 1'b0;
    // sets win over clears
    if (ovf0) st_d.ctrl[`DTC_B_TF0] = 1'b1;
    if (ovf_th0) st_d.ctrl[`DTC_B_TF1] = 1'b1;
    if (ovf1 && m0 != dtc_pkg::DTC_MODE_SPLIT) st_d.ctrl[`DTC_B_TF1] = 1'b1;
    // edge or level external request
    if (st_q.ctrl[`DTC_B_IT0] ? ext_fall[0] : !pin_q[0]) st_d.ctrl[`DTC_B_IE0] = 1'b1;
    if (st_q.ctrl[`DTC_B_IT1] ? ext_fall[1] : !pin_q[1]) st_d.ctrl[`DTC_B_IE1] = 1'b1;
    if (!st_q.ctrl[`DTC_B_IT0] && pin_q[0]) st_d.ctrl[`DTC_B_IE0] = 1'b0;
    if (!st_q.ctrl[`DTC_B_IT1] && pin_q[1]) st_d.ctrl[`DTC_B_IE1] = 1'b0;

    // sticky status, set beats read clear
    if (ovf0) st_d.st[`DTC_ST_OVF0] = 1'b1;
    if (ovf_th0 || (ovf1 && m0 != dtc_pkg::DTC_MODE_SPLIT)) st_d.st[`DTC_ST_OVF1] = 1'b1;
    if (st_d.ctrl[`DTC_B_IE0] && !st_q.ctrl[`DTC_B_IE0]) st_d.st[`DTC_ST_EXT0] = 1'b1;
    if (st_d.ctrl[`DTC_B_IE1] && !st_q.ctrl[`DTC_B_IE1]) st_d.st[`DTC_ST_EXT1] = 1'b1;
  end

  // state register; pins idle high at reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{irs1: 3'h3, irs2: 2'h3, irs3: 2'h3, iflt: 2'h3, default: '0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // outputs; waitrequest drops in the ack cycle
  assign avs_waitrequest  = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata     = st_q.rdata;
  assign timer1_ovf_pulse = st_q.ovf1p;
  assign irq              = |(st_q.st & st_q.msk);
endmodule

// File: sim/dtc_asserts.sv
`timescale 1ns/1ps
`include "dtc_cfg.svh"
// ==============================================
// port checks of the timer block
module dtc_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // events
  input wire logic        timer1_ovf_pulse,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic req;
  // any access in flight
  assign req = avs_read | avs_write;
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait on first access cycle");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[3]
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_pulse_gap: assert property (timer1_ovf_pulse |=> !timer1_ovf_pulse [*5])
    else $error("overflows closer than a machine cycle");
  a_mask_off: assert property (avs_write && !avs_waitrequest && avs_address == `DTC_OFS_IRQ_MSK
    && avs_writedata[3:0] == 4'h0 |=> !irq)
    else $error("irq high with all masked");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !timer1_ovf_pulse
    && avs_readdata == 32'h0)
    else $error("outputs busy after reset");
  // main scenarios reached
  c_read: cover property (avs_read && !avs_waitrequest);
  c_pulse: cover property (timer1_ovf_pulse);
  c_irq: cover property ($rose(irq));
endmodule
bind dtc_top dtc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer1_ovf_pulse(timer1_ovf_pulse), .irq(irq));

// File: sim/dtc_pin_model.sv
`timescale 1ns/1ps
// ==============================================
// count pin source and gate pin levels
module dtc_pin_model (
  // clock
  input  wire logic       ref_clk,
  // commands
  input  wire logic       go,
  input  wire logic [7:0] edges,
  input  wire logic [7:0] hold,
  input  wire logic [1:0] irq_lvl,
  // pins
  output logic [1:0]      count_pin,
  output logic [1:0]      ext_irq_pin_n,
  output logic            busy
);
  logic [8:0] left_q = 9'h0;
  logic [7:0] cnt_q = 8'h0;
  logic       pin0_q = 1'b1; // idle high between bursts
  assign count_pin = {1'b1, pin0_q};
  // gate pins follow the bench level
  assign ext_irq_pin_n = irq_lvl;
  assign busy = left_q != 9'h0;
  // hold of six clocks is the fastest legal rate, so each level is seen once
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      left_q <= {edges, 1'b0};
      cnt_q  <= hold;
    end else if (busy && cnt_q == 8'h1) begin
      pin0_q       <= ~pin0_q;
      left_q       <= left_q - 9'h1;
      cnt_q        <= hold;
    end else if (busy) begin
      cnt_q <= cnt_q - 8'h1;
    end
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "dtc_cfg.svh"
// ==============================================
// register level regression
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  count_pin;
  logic [1:0]  ext_irq_pin_n;
  logic [1:0]  ovf_ack = 2'h0;
  logic [1:0]  ext_irq_ack = 2'h0;
  logic        timer1_ovf_pulse;
  logic        irq;
  logic        go = 1'b0;
  logic        busy;
  logic [1:0]  irq_lvl = 2'h3;
  logic [31:0] v;
  int          err_total = 0;
  int          checked = 0;
  int          pulses = 0;
  always #5 ref_clk = ~ref_clk;
  dtc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_pin(count_pin),
    .ext_irq_pin_n(ext_irq_pin_n), .ovf_ack(ovf_ack), .ext_irq_ack(ext_irq_ack),
    .timer1_ovf_pulse(timer1_ovf_pulse), .irq(irq));
  dtc_pin_model peer (.ref_clk(ref_clk), .go(go), .edges(8'h0a), .hold(8'h06),
    .irq_lvl(irq_lvl), .count_pin(count_pin), .ext_irq_pin_n(ext_irq_pin_n), .busy(busy));
  // baud pulses seen
  always @(posedge ref_clk) if (timer1_ovf_pulse === 1'b1) pulses <= pulses + 1;
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // request held until wait drops, then one idle cycle
  task wr(input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask
  task end_of_test;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // whole run is near 800 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rc(`DTC_OFS_CTRL, 32'hff, 32'h0);
    rc(4'h9, 32'hffffffff, 32'h0);
    // timer one reload
    wr(`DTC_OFS_IRQ_MSK, 32'h2);
    wr(`DTC_OFS_TH1, 32'hf0);
    wr(`DTC_OFS_TL1, 32'hfe);
    wr(`DTC_OFS_MODE, 32'h20);
    wr(`DTC_OFS_CTRL, 32'h40);
    repeat (120) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    rc(`DTC_OFS_TH1, 32'hff, 32'hf0);
    rc(`DTC_OFS_TL1, 32'hf0, 32'hf0);
    rc(`DTC_OFS_CTRL, 32'h80, 32'h80);
    chk({31'h0, pulses != 0}, 32'h1);
    wr(`DTC_OFS_CTRL, 32'h0);
    rc(`DTC_OFS_CTRL, 32'h80, 32'h0);
    rc(`DTC_OFS_IRQ_ST, 32'h2, 32'h2);
    rc(`DTC_OFS_IRQ_ST, 32'h2, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // flag set by software, cleared by acknowledge
    wr(`DTC_OFS_CTRL, 32'h20);
    ovf_ack <= 2'h1;
    @(posedge ref_clk);
    ovf_ack <= 2'h0;
    @(posedge ref_clk);
    rc(`DTC_OFS_CTRL, 32'h20, 32'h0);
    // ten falls at the highest rate
    wr(`DTC_OFS_TL0, 32'h0);
    wr(`DTC_OFS_MODE, 32'h05);
    wr(`DTC_OFS_CTRL, 32'h10);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do @(posedge ref_clk); while (busy);
    repeat (18) @(posedge ref_clk);
    rc(`DTC_OFS_TL0, 32'hff, 32'h0a);
    // gate pin of timer one held low, then released
    wr(`DTC_OFS_CTRL, 32'h0);
    irq_lvl <= 2'h1;
    wr(`DTC_OFS_TL1, 32'h0);
    wr(`DTC_OFS_MODE, 32'h90);
    wr(`DTC_OFS_CTRL, 32'h40);
    repeat (60) @(posedge ref_clk);
    rc(`DTC_OFS_TL1, 32'hff, 32'h0);
    irq_lvl <= 2'h3;
    repeat (60) @(posedge ref_clk);
    rc(`DTC_OFS_TL1, 32'hf8, 32'h08);
    // split timer zero, timer one parked in mode three
    wr(`DTC_OFS_TH0, 32'h0);
    wr(`DTC_OFS_TL0, 32'h55);
    wr(`DTC_OFS_MODE, 32'h33);
    rd(`DTC_OFS_TL1, v);
    repeat (60) @(posedge ref_clk);
    rc(`DTC_OFS_TH0, 32'hf8, 32'h08);
    rc(`DTC_OFS_TL0, 32'hff, 32'h55);
    rc(`DTC_OFS_TL1, 32'hff, v);
    // timer zero split: timer one runs out of mode three, run bit clear
    wr(`DTC_OFS_CTRL, 32'h0);
    wr(`DTC_OFS_TH1, 32'hfe);
    wr(`DTC_OFS_TL1, 32'hfe);
    wr(`DTC_OFS_MODE, 32'h23);
    v = pulses;
    repeat (30) @(posedge ref_clk);
    chk({31'h0, pulses > v}, 32'h1);
    rc(`DTC_OFS_CTRL, 32'h80, 32'h0);
    rc(`DTC_OFS_IRQ_ST, 32'h2, 32'h0);
    // thirteen bit carry out of the five bit prescaler, with a freeze
    wr(`DTC_OFS_CTRL, 32'h0);
    wr(`DTC_OFS_MODE, 32'h0);
    wr(`DTC_OFS_TH0, 32'h0);
    wr(`DTC_OFS_TL0, 32'h1e);
    wr(`DTC_OFS_CTRL, 32'h10);
    clk_en <= 1'b0;
    repeat (120) @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (30) @(posedge ref_clk);
    rc(`DTC_OFS_TH0, 32'hff, 32'h01);
    rc(`DTC_OFS_TL0, 32'h10, 32'h00);
    // external request, edge then level type
    wr(`DTC_OFS_CTRL, 32'h01);
    irq_lvl <= 2'h2;
    repeat (8) @(posedge ref_clk);
    rc(`DTC_OFS_CTRL, 32'h02, 32'h02);
    ext_irq_ack <= 2'h1;
    @(posedge ref_clk);
    ext_irq_ack <= 2'h0;
    @(posedge ref_clk);
    rc(`DTC_OFS_CTRL, 32'h02, 32'h0);
    wr(`DTC_OFS_CTRL, 32'h0);
    repeat (4) @(posedge ref_clk);
    rc(`DTC_OFS_CTRL, 32'h02, 32'h02);
    // external request status unmasked, then everything masked
    wr(`DTC_OFS_IRQ_MSK, 32'hf);
    chk({31'h0, irq}, 32'h1);
    wr(`DTC_OFS_IRQ_MSK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_of_test();
  end
endmodule
